// *** include/scl_consts.vh ***
// Constants for the signed configuration loader
`ifndef SCL_CONSTS_VH
`define SCL_CONSTS_VH
`define SCL_TAG_SIGN_KEY    8'h56
`define SCL_SIGN_KEY_LEN    8'h11
`define SCL_KEY_BYTES       5'h10
`define SCL_OPT_SPECIFIED   8'h20
`define SCL_OPT_DIV_MSB     5
`define SCL_OPT_DIV_LSB     4
`define SCL_DIV_ASIS        2'h0
`define SCL_DIV_SAM         2'h1
`define SCL_DIV_HMAC        2'h2
`define SCL_DIV_RSVD        2'h3
`define SCL_FILE_BYTES      10'h200
`define SCL_LAST_BYTE       9'h1FF
`define SCL_MAX_VAL_LEN     8'h18
`define SCL_TAG_SIGNATURE   8'h00
`define SCL_TAG_CARD_KEY    8'h80
`define SCL_CARD_KEY_LEN    8'h06
`define SCL_SIG_BYTES       5'h10
`define SCL_GEN_LO          8'h60
`define SCL_GEN_HI          8'h6F
`define SCL_ADDR_CTRL       4'h0
`define SCL_ADDR_STATUS     4'h1
`define SCL_ADDR_OPT        4'h2
`define SCL_ADDR_COUNT      4'h3
`define SCL_ADDR_SIG_SEL    4'h4
`define SCL_ADDR_SIG_DATA   4'h5
`define SCL_ADDR_CALC_SEL   4'h6
`define SCL_ADDR_CALC_DATA  4'h7
`define SCL_ADDR_IMG        4'h8
`define SCL_CTRL_START      0
`define SCL_CTRL_SIG_OK     1
`define SCL_CTRL_SIG_BAD    2
`endif

// *** core/scl_sig_compare.v ***
// Constant-time comparison of received and computed signatures
`timescale 1ns/1ps
`default_nettype none
module scl_sig_compare (
  input  wire         clk_sys,
  input  wire         reset_n,
  input  wire         clear,
  input  wire         byte_valid,
  input  wire [7:0]   sig_byte,
  input  wire [7:0]   calc_byte,
  output reg          mismatch_q
);
  // Accumulates every byte so timing never leaks the first difference
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mismatch_q <= 1'b0;
    end else if (clear) begin
      mismatch_q <= 1'b0;
    end else if (byte_valid && (sig_byte != calc_byte)) begin
      mismatch_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** core/scl_loader.v ***
// Signed configuration loader: image check, record parse and commit
`timescale 1ns/1ps
`default_nettype none
`include "scl_consts.vh"
module scl_loader (
  input  wire         clk_sys,
  input  wire         reset_n,
  input  wire [3:0]   reg_addr,
  input  wire [31:0]  reg_wdata,
  input  wire         reg_wr,
  input  wire         reg_rd,
  output reg  [31:0]  reg_rdata_q,
  output reg          nvm_write_q,
  output reg          nvm_delete_q,
  output reg  [7:0]   nvm_tag_q,
  output reg  [4:0]   nvm_len_q,
  output reg  [7:0]   nvm_data_q,
  output reg  [4:0]   nvm_idx_q,
  output reg          key_write_q,
  output reg  [6:0]   key_index_q,
  output reg  [2:0]   key_byte_idx_q,
  output reg  [7:0]   key_byte_q,
  output reg          general_q,
  output reg  [1:0]   div_mode_q,
  output reg  [7:0]   base_signing_key_q,
  output reg  [3:0]   base_signing_key_idx_q
);
  localparam ST_IDLE   = 3'h0;
  localparam ST_CHECK  = 3'h1;
  localparam ST_TAG    = 3'h2;
  localparam ST_LEN    = 3'h3;
  localparam ST_VAL    = 3'h4;
  localparam ST_DONE   = 3'h5;
  localparam ST_FAIL   = 3'h6;

  // Image store: full 512 bytes so the hash engine sees the padding too
  reg [7:0]  img_mem [0:511];
  reg [7:0]  sig_mem [0:15];
  reg [7:0]  calc_mem [0:15];
  reg [8:0]  img_ptr_q;
  reg [8:0]  rd_ptr_q;
  // Combinational read so each parse state sees the byte it points at
  wire [7:0] rd_byte = img_mem[rd_ptr_q];
  reg [2:0]  state_q;
  reg [7:0]  tag_q;
  reg [7:0]  len_q;
  reg [7:0]  cnt_q;
  reg [4:0]  chk_q;
  reg        done_q;
  reg        ok_q;
  reg        fmt_err_q;
  reg        sig_bad_q;
  reg        busy_q;
  reg [7:0]  opt_q;
  reg [3:0]  sig_sel_q;
  reg [3:0]  calc_sel_q;
  reg [9:0]  img_count_q;
  wire       mismatch;

  function is_card_key;
    input [7:0] t;
    begin
      is_card_key = (t[7] == 1'b1);
    end
  endfunction

  wire start    = reg_wr && reg_addr == `SCL_ADDR_CTRL && reg_wdata[`SCL_CTRL_START];
  wire host_ok  = reg_wr && reg_addr == `SCL_ADDR_CTRL && reg_wdata[`SCL_CTRL_SIG_OK];
  wire host_bad = reg_wr && reg_addr == `SCL_ADDR_CTRL && reg_wdata[`SCL_CTRL_SIG_BAD];
  wire chk_run  = (state_q == ST_CHECK) && (chk_q < `SCL_SIG_BYTES);

  scl_sig_compare u_cmp (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .clear      (start && !busy_q),
    .byte_valid (chk_run),
    .sig_byte   (sig_mem[chk_q[3:0]]),
    .calc_byte  (calc_mem[chk_q[3:0]]),
    .mismatch_q (mismatch)
  );

  // Memory writes have no reset; contents are refilled before each start
  always @(posedge clk_sys) begin
    if (reg_wr && reg_addr == `SCL_ADDR_IMG && !busy_q)
      img_mem[img_ptr_q] <= reg_wdata[7:0];
    if (reg_wr && reg_addr == `SCL_ADDR_SIG_DATA)
      sig_mem[sig_sel_q] <= reg_wdata[7:0];
    if (reg_wr && reg_addr == `SCL_ADDR_CALC_DATA)
      calc_mem[calc_sel_q] <= reg_wdata[7:0];
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= 32'h0; img_ptr_q <= 9'h0; img_count_q <= 10'h0;
      opt_q <= `SCL_OPT_SPECIFIED; sig_sel_q <= 4'h0; calc_sel_q <= 4'h0;
    end else begin
      if (reg_wr && reg_addr == `SCL_ADDR_OPT)
        opt_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `SCL_ADDR_SIG_SEL)
        sig_sel_q <= reg_wdata[3:0];
      if (reg_wr && reg_addr == `SCL_ADDR_CALC_SEL)
        calc_sel_q <= reg_wdata[3:0];
      if (start) begin
        img_ptr_q <= 9'h0;
        img_count_q <= 10'h0;
      end else if (reg_wr && reg_addr == `SCL_ADDR_IMG && !busy_q) begin
        img_ptr_q <= img_ptr_q + 9'h1;
        if (img_count_q != `SCL_FILE_BYTES)
          img_count_q <= img_count_q + 10'h1;
      end
      reg_rdata_q <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          `SCL_ADDR_STATUS: reg_rdata_q <= {26'h0, sig_bad_q, fmt_err_q, ok_q, done_q, busy_q,
                                             (img_count_q == `SCL_FILE_BYTES)};
          `SCL_ADDR_OPT:    reg_rdata_q <= {24'h0, opt_q};
          `SCL_ADDR_COUNT:  reg_rdata_q <= {22'h0, img_count_q};
          default:          reg_rdata_q <= 32'h0;
        endcase
      end
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE; rd_ptr_q <= 9'h0; tag_q <= 8'h0; len_q <= 8'h0;
      cnt_q <= 8'h0; chk_q <= 5'h0; done_q <= 1'b0; ok_q <= 1'b0;
      fmt_err_q <= 1'b0; sig_bad_q <= 1'b0; busy_q <= 1'b0;
      nvm_write_q <= 1'b0; nvm_delete_q <= 1'b0; nvm_tag_q <= 8'h0;
      nvm_len_q <= 5'h0; nvm_data_q <= 8'h0; nvm_idx_q <= 5'h0;
      key_write_q <= 1'b0; key_index_q <= 7'h0; key_byte_idx_q <= 3'h0;
      key_byte_q <= 8'h0; general_q <= 1'b0; div_mode_q <= `SCL_DIV_HMAC;
      base_signing_key_q <= 8'h0; base_signing_key_idx_q <= 4'h0;
    end else begin
      nvm_write_q <= 1'b0;
      nvm_delete_q <= 1'b0;
      key_write_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            busy_q <= 1'b1; done_q <= 1'b0; ok_q <= 1'b0;
            fmt_err_q <= 1'b0; sig_bad_q <= 1'b0; chk_q <= 5'h0;
            div_mode_q <= opt_q[`SCL_OPT_DIV_MSB:`SCL_OPT_DIV_LSB];
            // Short image cannot be signed over the full file
            if (img_count_q != `SCL_FILE_BYTES) begin
              fmt_err_q <= 1'b1;
              state_q <= ST_FAIL;
            end else begin
              state_q <= ST_CHECK;
            end
          end
        end
        ST_CHECK: begin
          // Host hash engine covers all 512 bytes and writes the result
          if (chk_run)
            chk_q <= chk_q + 5'h1;
          else if (host_bad || (host_ok && mismatch) ||
                   opt_q[`SCL_OPT_DIV_MSB:`SCL_OPT_DIV_LSB] == `SCL_DIV_RSVD) begin
            sig_bad_q <= 1'b1;
            state_q <= ST_FAIL;
          end else if (host_ok) begin
            rd_ptr_q <= 9'h0;
            state_q <= ST_TAG;
          end
        end
        ST_TAG: begin
          tag_q <= rd_byte;
          rd_ptr_q <= rd_ptr_q + 9'h1;
          state_q <= ST_LEN;
        end
        ST_LEN: begin
          len_q <= rd_byte;
          cnt_q <= 8'h0;
          rd_ptr_q <= rd_ptr_q + 9'h1;
          if (tag_q == `SCL_TAG_SIGNATURE || rd_ptr_q == `SCL_LAST_BYTE) begin
            state_q <= ST_DONE;
          end else if (rd_byte > `SCL_MAX_VAL_LEN ||
                       (is_card_key(tag_q) && rd_byte != `SCL_CARD_KEY_LEN &&
                        rd_byte != 8'h0) ||
                       (tag_q == `SCL_TAG_SIGN_KEY && rd_byte != `SCL_SIGN_KEY_LEN &&
                        rd_byte != 8'h0)) begin
            fmt_err_q <= 1'b1;
            state_q <= ST_FAIL;
          end else if (rd_byte == 8'h0) begin
            // Pointer already moves past the length byte to the next tag
            nvm_delete_q <= 1'b1;
            nvm_tag_q <= tag_q;
            nvm_len_q <= 5'h0;
            state_q <= ST_TAG;
          end else begin
            state_q <= ST_VAL;
          end
        end
        ST_VAL: begin
          cnt_q <= cnt_q + 8'h1;
          rd_ptr_q <= rd_ptr_q + 9'h1;
          general_q <= (tag_q >= `SCL_GEN_LO) && (tag_q <= `SCL_GEN_HI);
          if (is_card_key(tag_q)) begin
            key_write_q <= 1'b1;
            key_index_q <= tag_q[6:0] - 7'h0;
            key_byte_idx_q <= cnt_q[2:0];
            key_byte_q <= rd_byte;
          end else begin
            nvm_write_q <= 1'b1;
            nvm_tag_q <= tag_q;
            nvm_len_q <= len_q[4:0];
            nvm_idx_q <= cnt_q[4:0];
            nvm_data_q <= rd_byte;
            if (tag_q == `SCL_TAG_SIGN_KEY && cnt_q != 8'h0) begin
              base_signing_key_q <= rd_byte;
              base_signing_key_idx_q <= cnt_q[3:0] - 4'h1;
            end
          end
          if (cnt_q + 8'h1 == len_q) begin
            state_q <= ST_TAG;
          end
        end
        ST_DONE: begin
          done_q <= 1'b1; ok_q <= 1'b1; busy_q <= 1'b0;
          state_q <= ST_IDLE;
        end
        ST_FAIL: begin
          done_q <= 1'b1; busy_q <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** testbench/scl_card_model.sv ***
// Programming card model: configuration image and signature file
`timescale 1ns/1ps
`default_nettype none
module scl_card_model (
  input  wire logic [8:0] img_idx,
  input  wire logic [3:0] sig_idx,
  output logic      [7:0] img_byte,
  output logic      [7:0] sig_byte
);
  logic [7:0] img [0:511];
  initial begin
    for (int i = 0; i < 512; i++) img[i] = 8'h00; // Zero padding
    {img[0], img[1], img[2], img[3]} = {8'h61, 8'h02, 8'hAA, 8'hBB};
    {img[4], img[5], img[6], img[7]} = {8'h62, 8'h00, 8'h83, 8'h06};
    for (int i = 0; i < 6; i++) img[8+i] = 8'hD0 + 8'(i);
    {img[14], img[15], img[16]} = {8'h56, 8'h11, 8'h20};
    for (int i = 0; i < 16; i++) img[17+i] = 8'hC0 + 8'(i);
    {img[33], img[34]} = {8'h00, 8'h10}; // Signature last
  end
  assign img_byte = img[img_idx];
  assign sig_byte = 8'h5A ^ {4'h0, sig_idx};
endmodule
`default_nettype wire

// *** testbench/scl_loader_sva.sv ***
// Port checker for the configuration loader
`timescale 1ns/1ps
`default_nettype none
module scl_loader_sva (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        nvm_write_q,
  input wire logic        nvm_delete_q,
  input wire logic [7:0]  nvm_tag_q,
  input wire logic [4:0]  nvm_len_q,
  input wire logic [4:0]  nvm_idx_q,
  input wire logic        key_write_q,
  input wire logic [2:0]  key_byte_idx_q,
  input wire logic [1:0]  div_mode_q
);
  logic ok_q;
  wire  ctrl_wr = reg_wr && reg_addr == 4'h0;
  // Host approval seen since the last start
  always @(posedge clk_sys or negedge reset_n)
    if (!reset_n) ok_q <= 1'b0;
    else if (ctrl_wr && reg_wdata[0]) ok_q <= 1'b0;
    else if (ctrl_wr && reg_wdata[1]) ok_q <= 1'b1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  commit_after_ok_a: assert property (
    (nvm_write_q || nvm_delete_q || key_write_q) |-> ok_q) else $error("commit without approval");
  del_no_store_a: assert property (
    nvm_delete_q |-> !nvm_write_q && !key_write_q) else $error("delete also stored");
  zero_len_a: assert property (
    nvm_write_q |-> nvm_len_q != 5'h0) else $error("store of empty record");
  val_len_a: assert property (
    nvm_write_q |-> nvm_len_q <= 5'h18 && nvm_idx_q < nvm_len_q) else $error("value byte out of range");
  pad_skip_a: assert property (
    nvm_write_q |-> nvm_tag_q != 8'h00) else $error("padding stored");
  sign_len_a: assert property (
    nvm_write_q && nvm_tag_q == 8'h56 |-> nvm_len_q == 5'h11) else $error("signing key length");
  key_byte_a: assert property (
    key_write_q |-> key_byte_idx_q <= 3'h5) else $error("card key byte index");
  div_capture_a: assert property (
    $changed(div_mode_q) |-> $past(ctrl_wr && reg_wdata[0])) else $error("mode moved without start");
  cover property (key_write_q && key_byte_idx_q == 3'h5);
  cover property (nvm_delete_q);
  cover property (nvm_write_q && nvm_tag_q == 8'h61);
endmodule
bind scl_loader scl_loader_sva i_scl_loader_sva (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .nvm_write_q(nvm_write_q), .nvm_delete_q(nvm_delete_q),
  .nvm_tag_q(nvm_tag_q), .nvm_len_q(nvm_len_q), .nvm_idx_q(nvm_idx_q), .key_write_q(key_write_q),
  .key_byte_idx_q(key_byte_idx_q), .div_mode_q(div_mode_q));
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the configuration loader
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata_q, rv;
  logic        nvm_write_q, nvm_delete_q, key_write_q, general_q;
  logic [7:0]  nvm_tag_q, bkey, img_byte, sig_byte, del_tag;
  logic [6:0]  key_index_q, key_idx;
  logic [3:0]  bkey_idx, sig_idx;
  logic [1:0]  div_mode_q;
  logic [7:0]  nvm_data_q, key_byte_q;
  logic [4:0]  nvm_idx_q;
  logic [2:0]  key_byte_idx_q;
  logic [8:0]  img_idx;
  int          failures, n_tests, n_wr, n_del, n_key, n_gen, s_wr, s_del, s_key, s_gen;
  always #2.5 clk_sys = ~clk_sys;
  scl_loader i_scl_loader (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .nvm_write_q(nvm_write_q),
    .nvm_delete_q(nvm_delete_q), .nvm_tag_q(nvm_tag_q), .nvm_len_q(), .nvm_data_q(nvm_data_q),
    .nvm_idx_q(nvm_idx_q), .key_write_q(key_write_q), .key_index_q(key_index_q),
    .key_byte_idx_q(key_byte_idx_q), .key_byte_q(key_byte_q),
    .general_q(general_q), .div_mode_q(div_mode_q), .base_signing_key_q(bkey), .base_signing_key_idx_q(bkey_idx));
  scl_card_model i_scl_card_model (.img_idx(img_idx), .sig_idx(sig_idx), .img_byte(img_byte), .sig_byte(sig_byte));
  always @(posedge clk_sys) begin
    if (nvm_write_q) n_wr++;
    if (nvm_write_q && nvm_tag_q == 8'h61 && general_q) n_gen++;
    if (key_write_q) n_key++;
    if (key_write_q) key_idx = key_index_q;
    if (nvm_delete_q) n_del++;
    if (nvm_delete_q) del_tag = nvm_tag_q;
    if (key_write_q) chk({24'h0, key_byte_q}, 32'hD0 + 32'(key_byte_idx_q));
    if (nvm_write_q && nvm_tag_q == 8'h61) chk({24'h0, nvm_data_q}, nvm_idx_q[0] ? 32'hBB : 32'hAA);
    if (nvm_write_q && nvm_tag_q == 8'h56) chk({24'h0, nvm_data_q}, (nvm_idx_q == 5'h0) ? 32'h20 : 32'hBF + 32'(nvm_idx_q));
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata_q;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Mismatches %0d in %0d compares", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Load image, both signature copies, start, approve, poll status
  task automatic run(input logic [7:0] opt, input int nb, input logic [7:0] flip);
    int k;
    {s_wr, s_del, s_key, s_gen} = {n_wr, n_del, n_key, n_gen};
    wr(4'h2, {24'h0, opt});
    for (int i = 0; i < nb; i++) begin
      img_idx = 9'(i);
      #1;
      wr(4'h8, {24'h0, img_byte});
    end
    for (int i = 0; i < 16; i++) begin
      sig_idx = 4'(i);
      #1;
      wr(4'h4, 32'(i));
      wr(4'h5, {24'h0, sig_byte});
      wr(4'h6, 32'(i));
      wr(4'h7, {24'h0, sig_byte ^ flip});
    end
    wr(4'h0, 32'h1);
    repeat (17) @(posedge clk_sys);
    wr(4'h0, 32'h2);
    for (k = 0; k < 300; k++) begin
      rd(4'h1);
      if (rv[2] || rv[4] || rv[5]) break;
    end
    if (k == 300) begin
      failures++;
      wrap_up();
    end
  endtask
  initial begin
    {img_idx, sig_idx, failures, n_tests, n_wr, n_del, n_key, n_gen} = '0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1;
    chk({30'h0, div_mode_q}, 32'h2);
    rd(4'h2);
    chk(rv, 32'h20);
    rd(4'hF);
    chk(rv, 32'h0);
    for (int m = 0; m < 4; m++) begin
      run(8'(m << 4), 512, 8'h00);
      chk({30'h0, div_mode_q}, 32'(m));
      chk({31'h0, rv[5]}, {31'h0, m == 3});
      if (m == 3) chk(n_wr + n_del + n_key - s_wr - s_del - s_key, 0);
      else begin
        chk(n_del - s_del, 1);
        chk({24'h0, del_tag}, 32'h62);
        chk(n_key - s_key, 6);
        chk({25'h0, key_idx}, 32'h3);
        chk({20'h0, bkey_idx, bkey}, 32'hFCF);
        chk(n_wr - s_wr, 19);
        chk({31'h0, n_gen > s_gen}, 32'h1);
        chk({28'h0, rv[5:2]}, 32'h3);
      end
    end
    run(8'h20, 512, 8'h01);
    chk({31'h0, rv[5]}, 32'h1);
    chk(n_wr + n_del + n_key - s_wr - s_del - s_key, 0);
    run(8'h20, 511, 8'h00);
    chk({31'h0, rv[4]}, 32'h1);
    chk(n_wr + n_del + n_key - s_wr - s_del - s_key, 0);
    wrap_up();
  end
endmodule
`default_nettype wire
